// *** src/sda_pkg.sv ***
package sda_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_UPPER = 8'h00;
  localparam logic [7:0] ADDR_STAT2 = 8'h04;
  localparam logic [7:0] ADDR_LINK = 8'h08;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int EXT_W = 6;
  localparam int UNIT_W = 3;
  localparam int BIT_DATA_LATE = 15;
  localparam int BIT_WCHK = 14;
  localparam int BIT_MPAR = 13;
  localparam int BIT_NODRV = 12;
  localparam int BIT_NOMEM = 11;
  localparam int BIT_PROG = 10;
  localparam int BIT_MISSX = 9;
  localparam int BIT_IOPAR = 8;
  localparam int BIT_OUT_RDY = 7;
  localparam int BIT_IN_RDY = 6;
  localparam int BIT_CLEAR = 5;
  localparam int BIT_PTEST = 4;
  localparam int BIT_BAI = 3;
  localparam int BIT_TRE_CS1 = 14;
  localparam int BIT_A17_CS1 = 9;
  localparam int BIT_A16_CS1 = 8;
  localparam logic [EXT_W-1:0] EXT_RESET = 6'h00;
  localparam logic [7:0] ERR_RESET = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int DRV_ACK_NS = 1500;
  localparam int DRV_ACK_CYC = DRV_ACK_NS / CLK_NS;
  localparam int MISSX_US = 500;
  localparam int MISSX_CYC = (MISSX_US * 1000) / CLK_NS;
endpackage

// *** src/sda_core.sv ***
// Function
// - Upper six address bits sit above the sixteen-bit low address.
// - Extension counts up on carry, down on borrow.
// - Bits sixteen and seventeen writable here or via control register one.
// - Extension bits 15-6 read zero; 5-0 writable, cleared by init/clear.
// - Unit select bits 2-0 choose the responding drive.
// - Data late set when demand finds no word or no room.
// - Error flags hold until init, clear, error clear or go command.
// - Write-check mismatch sets flag, ends transfer, freezes buffer word.
// - Memory parity flag is OR of address and both data parity errors.
// - Missing drive set if no drive ack within 1.5 us of strobe.
// - Missing memory set when DMA address does not respond.
// - Transfer command while busy sets program error, command suppressed.
// - Missed transfer set if drive does not start within 500 us.
// - I/O data parity checked on read and write-check only.
// - Any listed flag drives the transfer error summary.
// - Output ready while buffer holds a word; cleared by init/clear/read.
// - Input ready while buffer has room; clear when eight words held.
// - Writing one to write-only clear bit initializes controller and drives.
// - Parity test bit selects even generated parity; cleared by clear.
// - Parity test expects even data parity; control parity stays normal.
// - Writing one to summary bit of register one clears errors.
`timescale 1ns/1ps
module sda_core #(
  parameter int MISSX_CYCLES = sda_pkg::MISSX_CYC,
  parameter int BUF_WORDS = 8
) (
  // APB
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control register one interface
  input wire logic cs1_hi_we,
  input wire logic [1:0] cs1_a17_a16,
  input wire logic cs1_tre_wr1,
  input wire logic go_xfer_cmd,
  input wire logic busy,
  output logic transfer_error_summary,
  output logic cmd_suppress,
  // Address counting
  input wire logic low_carry,
  input wire logic low_borrow,
  input wire logic [15:0] dma_lower_address,
  output logic [21:0] dma_address,
  output logic [2:0] unit_sel,
  output logic addr_inc_inhibit,
  // Transfer events
  input wire logic read_mode,
  input wire logic wchk_mode,
  input wire logic write_mode,
  input wire logic drive_demand,
  input wire logic word_avail,
  input wire logic room_avail,
  input wire logic wchk_mismatch,
  input wire logic address_parity_error,
  input wire logic odd_word_data_parity_error,
  input wire logic even_word_data_parity_error,
  input wire logic controller_register_strobe,
  input wire logic drive_register_ack,
  input wire logic mem_timeout,
  input wire logic drive_started,
  input wire logic io_data_valid,
  input wire logic [15:0] io_data,
  input wire logic io_data_par,
  output logic xfer_abort,
  output logic freeze_buffer,
  output logic parity_even,
  output logic drive_init,
  // Buffer status
  input wire logic [3:0] buf_count
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  localparam int EXT_W_L = sda_pkg::EXT_W;
  localparam int UNIT_W_L = sda_pkg::UNIT_W;
  localparam int ERR_W = 8;
  // Register state
  logic [EXT_W_L-1:0] ext_reg;
  logic [EXT_W_L-1:0] ext_next;
  logic [UNIT_W_L-1:0] unit_reg;
  logic [UNIT_W_L-1:0] unit_next;
  logic ptest_reg;
  logic ptest_next;
  logic bai_reg;
  logic bai_next;
  // Error flag state, one cell per flag
  wire [ERR_W-1:0] err_reg;
  // Watchdog expiries
  wire drv_timeout;
  wire mx_timeout;
  wire wr_en = psel && penable && pwrite;
  wire hit_upper = paddr == sda_pkg::ADDR_UPPER;
  wire hit_stat2 = paddr == sda_pkg::ADDR_STAT2;
  wire hit_link = paddr == sda_pkg::ADDR_LINK;
  wire wr_upper = wr_en && hit_upper;
  wire wr_stat2 = wr_en && hit_stat2;
  wire ctl_clear = wr_stat2 && pwdata[sda_pkg::BIT_CLEAR];
  // Error clear or go loads reset flags
  wire err_clear = ctl_clear || cs1_tre_wr1 || (go_xfer_cmd && !busy);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_upper || hit_stat2 || hit_link);
  assign drive_init = ctl_clear;
  // ----------------------------------------
  // Address extension
  // ----------------------------------------
  // Full address
  assign dma_address = {ext_reg, dma_lower_address};
  always_comb begin
    ext_next = ext_reg;
    if (wr_upper) begin
      ext_next = pwdata[EXT_W_L-1:0];
    end else if (cs1_hi_we && !busy) begin
      ext_next = {ext_reg[EXT_W_L-1:2], cs1_a17_a16};
    end else if (low_carry) begin
      ext_next = ext_reg + 6'h01;
    end else if (low_borrow) begin
      ext_next = ext_reg - 6'h01;
    end
  end
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  // Unit select may change mid-transfer without harm
  assign unit_next = wr_stat2 ? pwdata[UNIT_W_L-1:0] : unit_reg;
  assign ptest_next = wr_stat2 ? pwdata[sda_pkg::BIT_PTEST] : ptest_reg;
  // Increment inhibit frozen while a transfer runs
  assign bai_next = (wr_stat2 && !busy) ? pwdata[sda_pkg::BIT_BAI] : bai_reg;
  // ----------------------------------------
  // Watchdogs
  // ----------------------------------------
  // Drive ack watchdog, restarted by each strobe that does not meet an ack or an expiry in its cycle
  sda_wdog #(
    .CNT_W(8),
    .LIMIT(sda_pkg::DRV_ACK_CYC)
  ) u_ack_wdog (
    .clock(clock),
    .rst_b(rst_b),
    .start(controller_register_strobe),
    .stop(drive_register_ack),
    .expired(drv_timeout)
  );
  // Command start watchdog; a clear abandons the wait
  sda_wdog #(
    .CNT_W(20),
    .LIMIT(MISSX_CYCLES)
  ) u_mx_wdog (
    .clock(clock),
    .rst_b(rst_b),
    .start(go_xfer_cmd && !busy),
    .stop(ctl_clear || drive_started),
    .expired(mx_timeout)
  );
  // ----------------------------------------
  // I/O bus data parity
  // ----------------------------------------
  // Odd total is good normally, even total under parity test
  wire io_par_sum = ^{io_data, io_data_par};
  wire io_par_bad = io_par_sum == ptest_reg;
  // ----------------------------------------
  // Error flags
  // ----------------------------------------
  logic [7:0] err_set;
  always_comb begin
    err_set = 8'h00;
    err_set[7] = drive_demand &&
      ((write_mode && !word_avail) || ((read_mode || wchk_mode) && !room_avail));
    err_set[6] = wchk_mode && wchk_mismatch;
    err_set[5] = address_parity_error || odd_word_data_parity_error ||
      even_word_data_parity_error;
    err_set[4] = drv_timeout;
    err_set[3] = mem_timeout;
    err_set[2] = go_xfer_cmd && busy;
    err_set[1] = mx_timeout;
    err_set[0] = io_data_valid && (read_mode || wchk_mode) && io_par_bad;
  end
  // One cell per flag; set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < ERR_W; gi++) begin : g_flag
      sda_flag #(
        .RESET_VAL(sda_pkg::ERR_RESET[gi])
      ) u_flag (
        .clock(clock),
        .rst_b(rst_b),
        .set_evt(err_set[gi]),
        .clr_evt(err_clear),
        .flag(err_reg[gi])
      );
    end
  endgenerate
  // ----------------------------------------
  // Transfer side outputs
  // ----------------------------------------
  // Error summary
  assign transfer_error_summary = |err_reg;
  assign cmd_suppress = go_xfer_cmd && busy;
  assign xfer_abort = err_set[6];
  assign freeze_buffer = err_reg[6];
  assign parity_even = ptest_reg;
  assign unit_sel = unit_reg;
  assign addr_inc_inhibit = bai_reg;
  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Buffer ready flags
  wire out_rdy = buf_count != 4'h0;
  wire in_rdy = buf_count < 4'(BUF_WORDS);
  // Status two word, built field by field
  logic [15:0] stat2_val;
  always_comb begin
    stat2_val = 16'h0000;
    stat2_val[sda_pkg::BIT_DATA_LATE:sda_pkg::BIT_IOPAR] = err_reg;
    stat2_val[sda_pkg::BIT_OUT_RDY] = out_rdy;
    stat2_val[sda_pkg::BIT_IN_RDY] = in_rdy;
    // Clear is write only and always reads zero
    stat2_val[sda_pkg::BIT_CLEAR] = 1'b0;
    stat2_val[sda_pkg::BIT_PTEST] = ptest_reg;
    stat2_val[sda_pkg::BIT_BAI] = bai_reg;
    stat2_val[UNIT_W_L-1:0] = unit_reg;
  end
  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_upper) begin
      prdata = {26'h000_0000, ext_reg};
    end else if (hit_stat2) begin
      prdata = {16'h0000, stat2_val};
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Init or controller clear empties the control fields
  wire fld_clear = !rst_b || ctl_clear;
  always_ff @(posedge clock) begin
    if (fld_clear) begin
      ext_reg <= sda_pkg::EXT_RESET;
    end else begin
      ext_reg <= ext_next;
    end
  end
  always_ff @(posedge clock) begin
    if (fld_clear) begin
      unit_reg <= 3'h0;
    end else begin
      unit_reg <= unit_next;
    end
  end
  always_ff @(posedge clock) begin
    if (fld_clear) begin
      ptest_reg <= 1'b0;
    end else begin
      ptest_reg <= ptest_next;
    end
  end
  always_ff @(posedge clock) begin
    if (fld_clear) begin
      bai_reg <= 1'b0;
    end else begin
      bai_reg <= bai_next;
    end
  end
endmodule // sda_core

// ----------------------------------------
// Error flag cell
// ----------------------------------------
module sda_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Events
  input wire logic set_evt,
  input wire logic clr_evt,
  // State
  output logic flag
);
  logic flag_reg;
  logic flag_next;
  // A set in the clear cycle survives, so no event is lost
  assign flag_next = (clr_evt ? 1'b0 : flag_reg) | set_evt;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flag_reg <= RESET_VAL;
    end else begin
      flag_reg <= flag_next;
    end
  end
  assign flag = flag_reg;
endmodule // sda_flag

// ----------------------------------------
// Cycle watchdog
// ----------------------------------------
module sda_wdog #(
  parameter int CNT_W = 8,
  parameter int LIMIT = 15
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control
  input wire logic start,
  input wire logic stop,
  // Result
  output logic expired
);
  // Limit must fit the counter width, or the truncated limit ends the wait early
  logic wait_reg;
  logic [CNT_W-1:0] cnt_reg;
  wire at_limit = cnt_reg == CNT_W'(LIMIT - 1);
  // A stop in the last cycle beats the expiry
  assign expired = wait_reg && !stop && at_limit;
  always_ff @(posedge clock) begin
    if (!rst_b || stop || expired) begin
      wait_reg <= 1'b0;
      cnt_reg <= {CNT_W{1'b0}};
    end else if (start) begin
      wait_reg <= 1'b1;
      cnt_reg <= {CNT_W{1'b0}};
    end else if (wait_reg) begin
      cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // sda_wdog

// *** dv/sda_monitor.sv ***
`timescale 1ns/1ps
module sda_mon (
  // Bus
  input wire logic clock, rst_b, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Control and events
  input wire logic go_xfer_cmd, busy, cmd_suppress, low_carry, cs1_hi_we,
  input wire logic drive_init, parity_even, wchk_mode, wchk_mismatch,
  input wire logic xfer_abort, transfer_error_summary, freeze_buffer,
  input wire logic [15:0] dma_lower_address,
  input wire logic [21:0] dma_address,
  input wire logic [2:0] unit_sel
);
  wire acc = psel && penable;
  wire rd_up = acc && !pwrite && paddr == sda_pkg::ADDR_UPPER;
  wire wr_up = acc && pwrite && paddr == sda_pkg::ADDR_UPPER;
  wire wr_st = acc && pwrite && paddr == sda_pkg::ADDR_STAT2;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  addr_join_a: assert property (dma_address[15:0] == dma_lower_address)
    else $error("low address lost");
  upper_zero_a: assert property (rd_up |-> prdata[31:6] == 26'h0)
    else $error("upper bits not zero");
  ext_carry_a: assert property (low_carry && !cs1_hi_we && !wr_up && !drive_init |=>
    dma_address[21:16] == $past(dma_address[21:16]) + 6'h01) else $error("no carry count");
  unit_load_a: assert property (wr_st && !pwdata[5] |=> unit_sel == $past(pwdata[2:0]))
    else $error("unit not loaded");
  ptest_load_a: assert property (wr_st && !pwdata[5] |=> parity_even == $past(pwdata[4]))
    else $error("parity test not loaded");
  clear_init_a: assert property (wr_st && pwdata[5] |-> drive_init ##1 !parity_even)
    else $error("clear not applied");
  cmd_block_a: assert property (go_xfer_cmd && busy |-> cmd_suppress)
    else $error("command not held back");
  wchk_stop_a: assert property (wchk_mismatch && wchk_mode |-> xfer_abort ##1 transfer_error_summary && freeze_buffer)
    else $error("mismatch not stopped");
endmodule // sda_mon
bind sda_core sda_mon u_mon (.*);

// *** dv/sda_drive.sv ***
`timescale 1ns/1ps
module sda_drv (
  // Register strobe
  input wire logic clock, rst_b, strobe, mute,
  input wire logic [3:0] dly,
  output logic ack,
  // Data section
  input wire logic pe, bad,
  output logic [15:0] data,
  output logic par
);
  logic [3:0] cnt;
  always @(posedge clock) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      data <= 16'h0;
    end else begin
      cnt <= strobe && !mute ? dly : (cnt == 4'h0 ? cnt : cnt - 4'h1);
      data <= {data[14:0], ~data[15]};
    end
  end
  // answer after dly, absent drive never
  assign ack = cnt == 4'h1;
  // odd parity, even under test, broken on command
  assign par = ^data ^ !pe ^ bad;
endmodule // sda_drv

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic clock=0, rst_b=0, psel=0, penable=0, pwrite=0, busy=0, bad=1, mute=0;
  logic drive_started=0, slv_err;
  logic cs1_hi_we=0, cs1_tre_wr1=0, go_xfer_cmd=0, low_carry=0, low_borrow=0;
  logic read_mode=0, wchk_mode=0, write_mode=0, controller_register_strobe=0;
  logic [7:0] paddr=0;
  logic [31:0] pwdata=0, prdata, rd, x;
  logic [1:0] cs1_a17_a16=0;
  logic [15:0] dma_lower_address=0, io_data;
  logic [3:0] buf_count=0, dly=4;
  logic [6:0] ev=0;
  logic [21:0] dma_address;
  logic [2:0] unit_sel;
  logic pready, pslverr, transfer_error_summary, cmd_suppress, addr_inc_inhibit, xfer_abort, io_data_par;
  logic freeze_buffer, parity_even, drive_init, drive_register_ack;
  wire word_avail = 1'b0, room_avail = 1'b1;
  wire address_parity_error = ev[0], odd_word_data_parity_error = ev[1];
  wire even_word_data_parity_error = ev[2], mem_timeout = ev[3];
  wire wchk_mismatch = ev[4], drive_demand = ev[5], io_data_valid = ev[6];
  int num_errors = 0, cmp_count = 0, seed = 32'h845d2da3;
  int fb[7] = '{13, 13, 13, 11, 14, 15, 8};
  sda_core #(.MISSX_CYCLES(20)) dut (.*);
  sda_drv u_drv (.clock, .rst_b, .strobe(controller_register_strobe), .mute, .dly,
    .ack(drive_register_ack), .pe(parity_even), .bad, .data(io_data), .par(io_data_par));
  initial begin
    forever #50 clock = ~clock;
  end
  task chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    tick(3);
    rst_b <= 1'b1;
    tick(1);
    for (int n = 0; n < 9; n++) begin
      buf_count <= n[3:0];
      apb(0, sda_pkg::ADDR_STAT2, 0);
      chk("stat2", rd, {24'h0, n != 0, n != 8, 6'h0});
    end
    $display("test buffer done");
    for (int i = 0; i < 4; i++) begin
      x = $random(seed);
      apb(1, sda_pkg::ADDR_UPPER, x);
      dma_lower_address <= x[31:16];
      apb(0, sda_pkg::ADDR_UPPER, 0);
      chk("ext", rd, {26'h0, x[5:0]});
      low_carry <= 1'b1;
      tick(1);
      low_carry <= 1'b0;
      tick(1);
      chk("carry", dma_address, {x[5:0] + 6'h01, x[31:16]});
      low_borrow <= 1'b1;
      tick(1);
      low_borrow <= 1'b0;
      tick(1);
      chk("borrow", dma_address[21:16], x[5:0]);
      cs1_a17_a16 <= x[7:6];
      cs1_hi_we <= 1'b1;
      tick(1);
      cs1_hi_we <= 1'b0;
      tick(1);
      chk("cs1 bits", dma_address[17:16], x[7:6]);
    end
    x = $random(seed);
    apb(1, sda_pkg::ADDR_STAT2, {x[31:6], 2'b01, x[3:0]});
    apb(0, sda_pkg::ADDR_STAT2, 0);
    chk("control", rd[5:0], {2'b01, x[3:0]});
    chk("inhibit", addr_inc_inhibit, x[3]);
    chk("unit out", unit_sel, x[2:0]);
    apb(0, sda_pkg::ADDR_LINK, 0);
    chk("link", {rd[30:0], slv_err}, 32'h0);
    apb(0, 8'h0c, 0);
    chk("unmapped", {rd[30:0], slv_err}, 32'h1);
    apb(1, sda_pkg::ADDR_STAT2, 32'h20);
    apb(0, sda_pkg::ADDR_UPPER, 0);
    chk("clear", {rd[5:0], parity_even}, 7'h0);
    $display("test control done");
    for (int i = 0; i < 7; i++) begin
      wchk_mode <= i == 4;
      read_mode <= i == 6;
      write_mode <= i < 6 && i != 4;
      tick(1);
      ev <= 7'h01 << i;
      tick(1);
      ev <= 7'h00;
      apb(0, sda_pkg::ADDR_STAT2, 0);
      chk("flag", {rd[15:8], transfer_error_summary}, {8'h01 << (fb[i] - 8), 1'b1});
      cs1_tre_wr1 <= 1'b1;
      tick(1);
      cs1_tre_wr1 <= 1'b0;
      tick(1);
      chk("error clear", transfer_error_summary, 1'b0);
    end
    $display("test flags done");
    for (int i = 0; i < 2; i++) begin
      x = $random(seed);
      mute <= i == 1;
      dly <= {1'b0, x[2:0]} + 4'h1;
      controller_register_strobe <= 1'b1;
      tick(1);
      controller_register_strobe <= 1'b0;
      tick(17);
      apb(0, sda_pkg::ADDR_STAT2, 0);
      chk("no drive", rd[12], i == 1);
    end
    for (int i = 0; i < 3; i++) begin
      cs1_tre_wr1 <= 1'b1;
      busy <= i == 1;
      tick(1);
      cs1_tre_wr1 <= 1'b0;
      go_xfer_cmd <= 1'b1;
      tick(1);
      go_xfer_cmd <= 1'b0;
      apb(0, sda_pkg::ADDR_STAT2, 0);
      chk("go", rd[15:8], i == 1 ? 8'h04 : 8'h00);
      drive_started <= i == 2;
      tick(1);
      drive_started <= 1'b0;
      tick(21);
      busy <= 1'b0;
      apb(0, sda_pkg::ADDR_STAT2, 0);
      chk("missed", rd[9], i == 0);
    end
    $display("test commands done");
    end_sim;
  end
  initial begin
    tick(3000);
    num_errors++;
    end_sim;
  end
endmodule // tb
